/* common/ldcd_pkg.sv */
// Purpose: shared constants and carriers for the function configuration decoder
// Assumes: 12 function slots, 12-bit base decode, 8-bit configuration data
// Notes: window table rows are indexed by function number
package ldcd_pkg;
	localparam int LDCD_NLD = 12;
	// ----------------------------------------------------------------
	// configuration port
	// ----------------------------------------------------------------
	localparam logic [7:0] LDCD_KEY_ENTER = 8'h55;
	localparam logic [7:0] LDCD_KEY_EXIT = 8'haa;
	localparam logic [11:0] LDCD_PORT_STRAP0 = 12'h02e;
	localparam logic [11:0] LDCD_PORT_STRAP1 = 12'h04e;
	localparam logic [1:0] LDCD_STRAP_WAIT = 2'h2;
	// ----------------------------------------------------------------
	// register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] LDCD_IDX_LDN = 8'h07;
	localparam logic [7:0] LDCD_IDX_PWR = 8'h22;
	localparam logic [7:0] LDCD_IDX_OSC = 8'h24;
	localparam logic [7:0] LDCD_IDX_PORT_LO = 8'h26;
	localparam logic [7:0] LDCD_IDX_PORT_HI = 8'h27;
	localparam logic [7:0] LDCD_IDX_ACT = 8'h30;
	localparam logic [7:0] LDCD_IDX_BASE_HI = 8'h60;
	localparam logic [7:0] LDCD_IDX_BASE_LO = 8'h61;
	localparam logic [7:0] LDCD_IDX_IRQ = 8'h70;
	localparam logic [7:0] LDCD_IDX_DMA = 8'h74;
	localparam logic [7:0] LDCD_IDX_RSV_LO = 8'ha9;
	localparam logic [7:0] LDCD_IDX_RSV_HI = 8'hdf;
	localparam int LDCD_OSC_Q16_BIT = 6;
	// ----------------------------------------------------------------
	// function numbers and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] LDCD_LDN_FDC = 4'h0;
	localparam logic [3:0] LDCD_LDN_PP = 4'h3;
	localparam logic [3:0] LDCD_LDN_SER2 = 4'h5;
	localparam logic [3:0] LDCD_LDN_KBD = 4'h7;
	localparam logic [11:0] LDCD_IMPL_MASK = 12'heb9;
	localparam logic [11:0] LDCD_RELOC_MASK = 12'he39;
	localparam logic [11:0] LDCD_DMA_MASK = 12'h029;
	localparam logic [3:0] LDCD_IRQ_FDC_RST = 4'h6;
	localparam logic [2:0] LDCD_DMA_FDC_RST = 3'h2;
	localparam logic [2:0] LDCD_DMA_PAR_RST = 3'h4;
	localparam logic [11:0] LDCD_KBD_DATA = 12'h060;
	localparam logic [11:0] LDCD_KBD_CMD = 12'h064;
	localparam logic [11:0] LDCD_PP_STD_SPAN = 12'h003;
	localparam logic [15:0] LDCD_PP_EPP_AMASK = 16'h0007;
	localparam logic [11:0] LDCD_ECP_OFF = 12'h400;
	localparam logic [11:0] LDCD_ECP_SPAN = 12'h003;
	// ----------------------------------------------------------------
	// base windows: lowest, highest, alignment mask, register span
	// ----------------------------------------------------------------
	localparam logic [11:0] LDCD_WIN_LO [LDCD_NLD] = '{12'h100, 12'h000, 12'h000, 12'h100,
		12'h100, 12'h100, 12'h000, 12'h000, 12'h000, 12'h100, 12'h000, 12'h100};
	localparam logic [11:0] LDCD_WIN_HI [LDCD_NLD] = '{12'hff8, 12'h000, 12'h000, 12'hffc,
		12'hff8, 12'hff8, 12'h000, 12'h000, 12'h000, 12'hfff, 12'hf7f, 12'hffe};
	localparam logic [11:0] LDCD_WIN_AMASK [LDCD_NLD] = '{12'h007, 12'h000, 12'h000, 12'h003,
		12'h007, 12'h007, 12'h000, 12'h000, 12'h000, 12'h000, 12'h07f, 12'h001};
	localparam logic [11:0] LDCD_WIN_SPAN [LDCD_NLD] = '{12'h008, 12'h000, 12'h000, 12'h008,
		12'h008, 12'h008, 12'h000, 12'h000, 12'h000, 12'h001, 12'h080, 12'h002};
	typedef enum logic [1:0] {LDCD_RUN = 2'b01, LDCD_CFG = 2'b10} ldcd_cfg_st_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ldcd_io_req_t;
	typedef struct packed {
		logic ack;
		logic claim;
		logic [7:0] rdata;
	} ldcd_io_rsp_t;
	typedef struct packed {
		logic hit;
		logic wr;
		logic rd;
		logic [3:0] ldn;
		logic [10:0] off;
		logic [7:0] wdata;
	} ldcd_dec_t;
	function automatic logic [3:0] ldcd_irq_rst(input int g);
		return (g == int'(LDCD_LDN_FDC)) ? LDCD_IRQ_FDC_RST : 4'h0;
	endfunction
	function automatic logic [2:0] ldcd_dma_rst(input int g);
		if (g == int'(LDCD_LDN_FDC)) return LDCD_DMA_FDC_RST;
		if (g == int'(LDCD_LDN_PP) || g == int'(LDCD_LDN_SER2)) return LDCD_DMA_PAR_RST;
		return 3'h0;
	endfunction
endpackage

/* rtl/ldcd_irq_route.sv */
// Purpose: steers function interrupt requests onto the numbered lines
// Assumes: requests are active-high levels on the bus clock
// Notes: line 0 is never driven
`timescale 1ns/1ps
module ldcd_irq_route
	import ldcd_pkg::*;
(
	input wire logic clk, // bus clock
	input wire logic nrst, // async reset, active low
	input wire logic [11:0][3:0] irq_sel, // per-function line select
	input wire logic [11:0] func_act, // per-function on
	input wire logic [11:0] func_req, // per-function request
	input wire logic pp_ext_mode, // parallel port in extended mode
	output logic [15:0] irq_line, // interrupt lines
	output logic sys_mgmt_int_n // management interrupt, low active
);
	logic [15:0] raw;
	logic [15:0] inv;
	// ----------------------------------------------------------------
	// line collection
	// ----------------------------------------------------------------
	always_comb begin
		raw = 16'h0000;
		inv = 16'h0000;
		for (int g = 0; g < LDCD_NLD; g++) begin
			if (func_act[g] && irq_sel[g] != 4'h0 && func_req[g]) begin
				raw[irq_sel[g]] = 1'b1;
			end
		end
		if (pp_ext_mode && irq_sel[LDCD_LDN_PP] != 4'h0) begin
			inv[irq_sel[LDCD_LDN_PP]] = 1'b1;
		end
		raw[0] = 1'b0;
	end
	// registered lines, high active except extended parallel mode
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_line <= 16'h0000;
		end else begin
			irq_line <= raw ^ inv;
		end
	end
	// line two also drives the management interrupt
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sys_mgmt_int_n <= 1'b1;
		end else begin
			sys_mgmt_int_n <= !raw[2];
		end
	end
	// any enabled function on line two pulls the management interrupt low
	for (genvar g = 0; g < LDCD_NLD; g++) begin : g_smi
		property p_smi;
			@(posedge clk) disable iff (!nrst)
			(func_act[g] && irq_sel[g] == 4'h2 && func_req[g]) |=> !sys_mgmt_int_n;
		endproperty
		a_smi: assert property (p_smi) else $error("line two request missing");
	end
endmodule

/* rtl/ldcd_top.sv */
// Purpose: configuration banks and i/o decode of a multi-function controller
// Assumes: one i/o request at most per clock, strap is an async pin
// Notes: answers and decode results appear one clock after the request
`timescale 1ns/1ps
// Behaviour
// - function number register selects which bank upper indices reach
// - per-function registers answer only in configuration state
// - index 60 holds base high byte, 61 the low byte
// - indices A9 to DF ignore writes and read zero
// - a function is on when activation or power bit is set
// - activation and power bits act as one bit
// - a base outside its window makes the function ignore host cycles
// - interrupt select resets to six for floppy, zero elsewhere
// - dma select resets to two for floppy, four for parallel, serial two
// - parallel base on 4 or 8 bytes; extended offsets need 8
// - parallel decodes offsets 0-2 and 400h-402h
// - keyboard function decodes fixed addresses 60 and 64
// - game port decodes one byte anywhere in 100-FFF
// - runtime block sits on 128-byte bases up to F7F
// - index at configuration base, data at base plus one
// - function bases decode on address bits 11 to 0
// - qualification bit also requires address bits 15-12 zero
// - configuration port starts at 2E or 4E from the strap
// - low four select bits pick line; two also management interrupt
// - lines are high active except extended parallel modes
module ldcd_top
	import ldcd_pkg::*;
(
	input wire logic clk, // bus clock
	input wire logic nrst, // async reset, active low
	input wire ldcd_pkg::ldcd_io_req_t io_req, // host i/o cycle
	output ldcd_pkg::ldcd_io_rsp_t io_rsp, // answer, next clock
	output ldcd_pkg::ldcd_dec_t dec, // function decode, next clock
	input wire logic cfg_port_strap, // strap pin
	input wire logic [11:0] func_irq_req, // function requests
	input wire logic pp_ext_mode, // parallel port extended mode
	output logic [15:0] irq_line, // interrupt lines
	output logic sys_mgmt_int_n, // management interrupt, low active
	output logic [11:0] func_on, // per-function on
	output logic [11:0][2:0] func_dma_sel // per-function dma select
);
	logic strap_s1_reg;
	logic strap_s2_reg;
	logic [1:0] strap_cnt_reg;
	logic strap_load;
	logic [11:0] port_reg;
	ldcd_cfg_st_t cfg_state_reg;
	logic [7:0] index_reg;
	logic [3:0] ldn_reg;
	logic [7:0] osc_reg;
	logic [11:0] act_reg;
	logic [15:0] base_reg [LDCD_NLD];
	logic [3:0] irq_reg [LDCD_NLD];
	logic [2:0] dma_reg [LDCD_NLD];
	ldcd_dec_t dec_reg;
	ldcd_io_rsp_t rsp_reg;
	logic first_reg;
	logic req;
	logic q16_ok;
	logic cfg_in;
	logic cfg_idx_hit;
	logic cfg_dat_hit;
	logic cfg_hit;
	logic wr_cfg;
	logic ld_ok;
	logic [3:0] ld_i;
	logic cur_act;
	logic [7:0] cfg_rdata;
	logic [11:0] win_ok;
	logic [11:0] win_hit;
	logic [11:0] win_rel [LDCD_NLD];
	logic ecp_hit;
	logic [11:0] ecp_rel;
	logic [11:0] fn_hit;
	logic [11:0] fn_rel [LDCD_NLD];
	logic [3:0] fn_sel;
	logic [11:0][3:0] irq_sel_pk;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] first_set(input logic [11:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int g = LDCD_NLD - 1; g >= 0; g--) begin
			if (v[g]) r = 4'(g);
		end
		return r;
	endfunction
	// ----------------------------------------------------------------
	// strap capture after reset release
	// ----------------------------------------------------------------
	// strap pin synchroniser
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			strap_s1_reg <= 1'b0;
			strap_s2_reg <= 1'b0;
		end else begin
			strap_s1_reg <= cfg_port_strap;
			strap_s2_reg <= strap_s1_reg;
		end
	end
	// wait for the synchroniser to fill, then load once
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			strap_cnt_reg <= 2'h0;
		end else if (strap_cnt_reg <= LDCD_STRAP_WAIT) begin
			strap_cnt_reg <= strap_cnt_reg + 2'h1;
		end
	end
	assign strap_load = (strap_cnt_reg == LDCD_STRAP_WAIT);
	// ----------------------------------------------------------------
	// configuration port decode
	// ----------------------------------------------------------------
	assign req = io_req.wr || io_req.rd;
	assign q16_ok = !osc_reg[LDCD_OSC_Q16_BIT] || (io_req.addr[15:12] == 4'h0);
	assign cfg_in = (cfg_state_reg == LDCD_CFG);
	assign cfg_idx_hit = q16_ok && (io_req.addr[11:0] == port_reg);
	assign cfg_dat_hit = q16_ok && (io_req.addr[11:0] == port_reg + 12'h001);
	assign cfg_hit = cfg_idx_hit || cfg_dat_hit;
	assign wr_cfg = io_req.wr && cfg_dat_hit && cfg_in;
	assign ld_ok = (ldn_reg < 4'(LDCD_NLD)) && LDCD_IMPL_MASK[ldn_reg];
	assign ld_i = ld_ok ? ldn_reg : 4'h0;
	assign cur_act = ld_ok && act_reg[ld_i];
	// port base: strap value, then software relocation on 2 bytes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			port_reg <= LDCD_PORT_STRAP0;
		end else if (strap_load) begin
			port_reg <= strap_s2_reg ? LDCD_PORT_STRAP1 : LDCD_PORT_STRAP0;
		end else if (wr_cfg && index_reg == LDCD_IDX_PORT_LO) begin
			port_reg[7:0] <= {io_req.wdata[7:1], 1'b0};
		end else if (wr_cfg && index_reg == LDCD_IDX_PORT_HI) begin
			port_reg[11:8] <= io_req.wdata[3:0];
		end
	end
	// key writes to the index port enter and leave configuration
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_state_reg <= LDCD_RUN;
		end else if (io_req.wr && cfg_idx_hit) begin
			unique case (cfg_state_reg)
				LDCD_RUN: begin
					if (io_req.wdata == LDCD_KEY_ENTER) cfg_state_reg <= LDCD_CFG;
				end
				LDCD_CFG: begin
					if (io_req.wdata == LDCD_KEY_EXIT) cfg_state_reg <= LDCD_RUN;
				end
			endcase
		end
	end
	// index register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			index_reg <= 8'h00;
		end else if (io_req.wr && cfg_idx_hit && cfg_in && io_req.wdata != LDCD_KEY_EXIT) begin
			index_reg <= io_req.wdata;
		end
	end
	// ----------------------------------------------------------------
	// global registers
	// ----------------------------------------------------------------
	// function number and clock/qualification control
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ldn_reg <= 4'h0;
			osc_reg <= 8'h00;
		end else if (wr_cfg && index_reg == LDCD_IDX_LDN) begin
			ldn_reg <= io_req.wdata[3:0];
		end else if (wr_cfg && index_reg == LDCD_IDX_OSC) begin
			osc_reg <= io_req.wdata;
		end
	end
	// one stored bit serves both activation and power control
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			act_reg <= 12'h000;
		end else if (wr_cfg && index_reg == LDCD_IDX_ACT && ld_ok) begin
			act_reg[ld_i] <= io_req.wdata[0];
		end else if (wr_cfg && index_reg == LDCD_IDX_PWR) begin
			act_reg[7:0] <= io_req.wdata & LDCD_IMPL_MASK[7:0];
		end
	end
	assign func_on = act_reg;
	// ----------------------------------------------------------------
	// per-function banks
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int g = 0; g < LDCD_NLD; g++) begin
				base_reg[g] <= 16'h0000;
				irq_reg[g] <= ldcd_irq_rst(g);
				dma_reg[g] <= ldcd_dma_rst(g);
			end
		end else if (wr_cfg && ld_ok) begin
			if (index_reg == LDCD_IDX_BASE_HI && LDCD_RELOC_MASK[ld_i]) begin
				base_reg[ld_i][15:8] <= io_req.wdata;
			end
			if (index_reg == LDCD_IDX_BASE_LO && LDCD_RELOC_MASK[ld_i]) begin
				base_reg[ld_i][7:0] <= io_req.wdata;
			end
			if (index_reg == LDCD_IDX_IRQ) begin
				irq_reg[ld_i] <= io_req.wdata[3:0];
			end
			if (index_reg == LDCD_IDX_DMA && LDCD_DMA_MASK[ld_i]) begin
				dma_reg[ld_i] <= io_req.wdata[2:0];
			end
		end
	end
	// read mux; unlisted indices, reserved range included, read zero
	always_comb begin
		cfg_rdata = 8'h00;
		if (cfg_idx_hit) begin
			cfg_rdata = index_reg;
		end else begin
			case (index_reg)
				LDCD_IDX_LDN: cfg_rdata = {4'h0, ldn_reg};
				LDCD_IDX_PWR: cfg_rdata = act_reg[7:0] & LDCD_IMPL_MASK[7:0];
				LDCD_IDX_OSC: cfg_rdata = osc_reg;
				LDCD_IDX_PORT_LO: cfg_rdata = port_reg[7:0];
				LDCD_IDX_PORT_HI: cfg_rdata = {4'h0, port_reg[11:8]};
				LDCD_IDX_ACT: cfg_rdata = {7'h00, cur_act};
				LDCD_IDX_BASE_HI: cfg_rdata = ld_ok ? base_reg[ld_i][15:8] : 8'h00;
				LDCD_IDX_BASE_LO: cfg_rdata = ld_ok ? base_reg[ld_i][7:0] : 8'h00;
				LDCD_IDX_IRQ: cfg_rdata = ld_ok ? {4'h0, irq_reg[ld_i]} : 8'h00;
				LDCD_IDX_DMA: cfg_rdata = ld_ok ? {5'h00, dma_reg[ld_i]} : 8'h00;
				default: cfg_rdata = 8'h00;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// function address windows
	// ----------------------------------------------------------------
	for (genvar g = 0; g < LDCD_NLD; g++) begin : g_win
		ldcd_win #(
			.P_LO(LDCD_WIN_LO[g]),
			.P_HI(LDCD_WIN_HI[g]),
			.P_AMASK(LDCD_WIN_AMASK[g]),
			.P_SPAN(LDCD_WIN_SPAN[g]),
			.P_OFF(12'h000)
		) u_win (
			.base(base_reg[g]),
			.addr(io_req.addr[11:0]),
			.ok(win_ok[g]),
			.hit(win_hit[g]),
			.rel(win_rel[g])
		);
	end
	// extended-capability registers above the parallel base
	ldcd_win #(
		.P_LO(LDCD_WIN_LO[LDCD_LDN_PP]),
		.P_HI(LDCD_WIN_HI[LDCD_LDN_PP]),
		.P_AMASK(LDCD_WIN_AMASK[LDCD_LDN_PP]),
		.P_SPAN(LDCD_ECP_SPAN),
		.P_OFF(LDCD_ECP_OFF)
	) u_ecp (
		.base(base_reg[LDCD_LDN_PP]),
		.addr(io_req.addr[11:0]),
		.ok(),
		.hit(ecp_hit),
		.rel(ecp_rel)
	);
	// per-function hits with parallel and keyboard special cases
	always_comb begin
		for (int g = 0; g < LDCD_NLD; g++) begin
			fn_hit[g] = act_reg[g] && q16_ok && win_hit[g];
			fn_rel[g] = win_rel[g];
		end
		fn_hit[LDCD_LDN_PP] = act_reg[LDCD_LDN_PP] && q16_ok && ((win_hit[LDCD_LDN_PP]
			&& (win_rel[LDCD_LDN_PP] < LDCD_PP_STD_SPAN
			|| (base_reg[LDCD_LDN_PP] & LDCD_PP_EPP_AMASK) == 16'h0000)) || ecp_hit);
		if (ecp_hit) fn_rel[LDCD_LDN_PP] = ecp_rel + LDCD_ECP_OFF;
		fn_hit[LDCD_LDN_KBD] = act_reg[LDCD_LDN_KBD] && q16_ok
			&& (io_req.addr[11:0] == LDCD_KBD_DATA || io_req.addr[11:0] == LDCD_KBD_CMD);
		fn_rel[LDCD_LDN_KBD] = io_req.addr[11:0] - LDCD_KBD_DATA;
	end
	assign fn_sel = first_set(fn_hit);
	// ----------------------------------------------------------------
	// answers
	// ----------------------------------------------------------------
	// decode result towards the functions
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dec_reg <= '0;
		end else begin
			dec_reg.hit <= req && !cfg_hit && (fn_hit != 12'h000);
			dec_reg.wr <= io_req.wr;
			dec_reg.rd <= io_req.rd;
			dec_reg.ldn <= fn_sel;
			dec_reg.off <= fn_rel[fn_sel][10:0];
			dec_reg.wdata <= io_req.wdata;
		end
	end
	// host answer; configuration data is claimed only in config state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg.ack <= req;
			rsp_reg.claim <= req && ((cfg_hit && cfg_in) || (!cfg_hit && fn_hit != 12'h000));
			rsp_reg.rdata <= (io_req.rd && cfg_hit && cfg_in) ? cfg_rdata : 8'h00;
		end
	end
	assign dec = dec_reg;
	assign io_rsp = rsp_reg;
	// ----------------------------------------------------------------
	// interrupt lines and dma selects
	// ----------------------------------------------------------------
	always_comb begin
		for (int g = 0; g < LDCD_NLD; g++) begin
			irq_sel_pk[g] = irq_reg[g];
			func_dma_sel[g] = dma_reg[g];
		end
	end
	ldcd_irq_route u_irq (
		.clk(clk),
		.nrst(nrst),
		.irq_sel(irq_sel_pk),
		.func_act(act_reg),
		.func_req(func_irq_req),
		.pp_ext_mode(pp_ext_mode),
		.irq_line(irq_line),
		.sys_mgmt_int_n(sys_mgmt_int_n)
	);
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) first_reg <= 1'b1;
		else first_reg <= 1'b0;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_rsv_rd;
		io_req.rd && cfg_dat_hit && cfg_in && index_reg >= LDCD_IDX_RSV_LO
			&& index_reg <= LDCD_IDX_RSV_HI;
	endsequence
	sequence s_act_wr;
		wr_cfg && index_reg == LDCD_IDX_ACT && ld_ok;
	endsequence
	property p_rsv;
		s_rsv_rd |=> io_rsp.ack && io_rsp.claim && io_rsp.rdata == 8'h00;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved index read not zero");
	property p_closed;
		io_req.rd && cfg_dat_hit && !cfg_in |=> !io_rsp.claim && io_rsp.rdata == 8'h00;
	endproperty
	a_closed: assert property (p_closed) else $error("answered outside config");
	property p_link;
		s_act_wr |=> cur_act == $past(io_req.wdata[0]) && func_on[ld_i] == cur_act;
	endproperty
	a_link: assert property (p_link) else $error("activation write lost");
	property p_pwr;
		wr_cfg && index_reg == LDCD_IDX_PWR |=> func_on[0] == $past(io_req.wdata[0]);
	endproperty
	a_pwr: assert property (p_pwr) else $error("power bit not linked");
	property p_irq_rst;
		first_reg |-> irq_reg[0] == LDCD_IRQ_FDC_RST && irq_reg[3] == 4'h0;
	endproperty
	a_irq_rst: assert property (p_irq_rst) else $error("bad interrupt reset");
	property p_dma_rst;
		first_reg |-> dma_reg[0] == LDCD_DMA_FDC_RST && dma_reg[5] == LDCD_DMA_PAR_RST;
	endproperty
	a_dma_rst: assert property (p_dma_rst) else $error("bad dma reset");
	property p_kbd;
		io_req.rd && act_reg[7] && q16_ok && !cfg_hit && io_req.addr[11:0] == LDCD_KBD_CMD
			|=> dec.hit && dec.ldn == LDCD_LDN_KBD && dec.off == 11'h004;
	endproperty
	a_kbd: assert property (p_kbd) else $error("keyboard decode wrong");
	property p_q16;
		req && osc_reg[LDCD_OSC_Q16_BIT] && io_req.addr[15:12] != 4'h0 |=> !dec.hit;
	endproperty
	a_q16: assert property (p_q16) else $error("upper address not qualified");
	property p_strap;
		strap_load |=> port_reg == ($past(strap_s2_reg) ? LDCD_PORT_STRAP1 : LDCD_PORT_STRAP0);
	endproperty
	a_strap: assert property (p_strap) else $error("strap port wrong");
	property p_epp;
		req && !ecp_hit && base_reg[3][2] && win_rel[3] >= LDCD_PP_STD_SPAN |=> !(dec.hit
			&& dec.ldn == LDCD_LDN_PP);
	endproperty
	a_epp: assert property (p_epp) else $error("extended cycle on 4-byte base");
endmodule

/* rtl/ldcd_win.sv */
// Purpose: checks one programmed base against its window and matches an address
// Assumes: 12-bit address decode, span zero means never decoded
// Notes: purely combinational
`timescale 1ns/1ps
module ldcd_win #(
	parameter logic [11:0] P_LO = 12'h000,
	parameter logic [11:0] P_HI = 12'h000,
	parameter logic [11:0] P_AMASK = 12'h000,
	parameter logic [11:0] P_SPAN = 12'h000,
	parameter logic [11:0] P_OFF = 12'h000
) (
	input wire logic [15:0] base, // programmed base
	input wire logic [11:0] addr, // host address low bits
	output logic ok, // base inside its window
	output logic hit, // address decoded
	output logic [11:0] rel // offset from base plus P_OFF
);
	// ----------------------------------------------------------------
	// range, alignment and offset match
	// ----------------------------------------------------------------
	assign ok = (P_SPAN != 12'h000) && (base[15:12] == 4'h0) && (base[11:0] >= P_LO)
		&& (base[11:0] <= P_HI) && ((base[11:0] & P_AMASK) == 12'h000);
	assign rel = addr - base[11:0] - P_OFF;
	assign hit = ok && (rel < P_SPAN);
endmodule

/* sim/ldcd_host.sv */
// Purpose: host side model issuing configuration i/o cycles
// Assumes: one-cycle request pulse, answer one clock later
// Notes: address and data inverted once released
`timescale 1ns/1ps
module ldcd_host
	import ldcd_pkg::*;
(
	input wire logic clk, // bus clock
	output ldcd_pkg::ldcd_io_req_t io_req, // request
	input wire ldcd_pkg::ldcd_io_rsp_t io_rsp // answer
);
	initial io_req = '0;
	// one transfer; answer taken once the ack edge has landed
	task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d,
		output ldcd_io_rsp_t r);
		@(posedge clk);
		io_req <= '{a, d, w, !w};
		@(posedge clk);
		io_req <= '{~a, ~d, 1'b0, 1'b0};
		#1 r = io_rsp;
	endtask
endmodule

/* sim/tb_ldcd_top.sv */
// Purpose: self-checking bench of the configuration decoder
// Assumes: strap low, port at 2e/2f
// Notes: random data from a fixed seed
`timescale 1ns/1ps
module tb_ldcd_top;
	import ldcd_pkg::*;
	logic clk, nrst, cfg_port_strap, pp_ext_mode;
	logic [15:0] port;
	logic [11:0] func_irq_req, func_on;
	ldcd_io_req_t io_req;
	ldcd_io_rsp_t io_rsp, r;
	ldcd_dec_t dec;
	logic [15:0] irq_line;
	logic sys_mgmt_int_n;
	logic [11:0][2:0] func_dma_sel;
	logic [7:0] x;
	logic [3:0] s;
	int miscompares, n_compared, seed, i;
	ldcd_top i_dut(.clk(clk), .nrst(nrst), .io_req(io_req), .io_rsp(io_rsp), .dec(dec),
		.cfg_port_strap(cfg_port_strap), .func_irq_req(func_irq_req),
		.pp_ext_mode(pp_ext_mode), .irq_line(irq_line), .sys_mgmt_int_n(sys_mgmt_int_n),
		.func_on(func_on), .func_dma_sel(func_dma_sel));
	ldcd_host i_host(.clk(clk), .io_req(io_req), .io_rsp(io_rsp));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		if (miscompares == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// index then data write
	task automatic wcfg(input logic [7:0] ix, input logic [7:0] d);
		i_host.cyc(1, port, ix, r);
		i_host.cyc(1, port + 16'h0001, d, r);
	endtask
	// index write then data read, claimed and acked
	task automatic rcfg(input logic [7:0] ix, input logic [7:0] e);
		i_host.cyc(1, port, ix, r);
		i_host.cyc(0, port + 16'h0001, 8'h00, r);
		chk({r.ack, r.claim, r.rdata}, {2'b11, e});
	endtask
	// host read and its decode result
	task automatic iord(input logic [15:0] a, input logic h, input logic [3:0] n,
		input logic [10:0] o);
		i_host.cyc(0, a, 8'h00, r);
		chk(h ? {dec.rd, dec.wr, dec.hit, dec.ldn, dec.off} : dec.hit,
			h ? {2'b10, h, n, o} : 1'b0);
	endtask
	function automatic logic [16:0] irq_of(input logic [3:0] sel);
		return {16'h0001 << sel, sel != 4'h2};
	endfunction
	// interrupt line settles one edge after the request, checked after two
	task automatic irq(input logic [11:0] q, input logic [16:0] e);
		@(posedge clk);
		func_irq_req <= q;
		repeat (2) @(posedge clk);
		#1 chk({irq_line, sys_mgmt_int_n}, e);
	endtask
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000 miscompares++;
		stop_test();
	end
	initial begin
		seed = 32'h9758;
		port = 16'h002e;
		{nrst, cfg_port_strap, pp_ext_mode, func_irq_req} = '0;
		repeat (16) @(posedge clk);
		chk({func_dma_sel[0], func_dma_sel[3], func_dma_sel[5]}, {3'h2, 3'h4, 3'h4});
		chk({func_on, irq_line, sys_mgmt_int_n}, 24'h1);
		nrst <= 1;
		repeat (4) @(posedge clk);
		i_host.cyc(1, 16'h002e, LDCD_KEY_ENTER, r);
		wcfg(LDCD_IDX_LDN, 8'h00);
		rcfg(LDCD_IDX_IRQ, 8'h06);
		wcfg(LDCD_IDX_LDN, 8'h03);
		rcfg(LDCD_IDX_IRQ, 8'h00);
		// reserved indices, both ends and random middle
		for (i = 0; i < 4; i++) begin
			x = (i == 0) ? 8'ha9 : (i == 1) ? 8'hdf : 8'ha9 + 8'({$random(seed)} % 55);
			wcfg(x, 8'($random(seed)));
			rcfg(x, 8'h00);
		end
		wcfg(LDCD_IDX_BASE_HI, 8'h03);
		wcfg(LDCD_IDX_BASE_LO, 8'h78);
		rcfg(LDCD_IDX_BASE_HI, 8'h03);
		rcfg(LDCD_IDX_BASE_LO, 8'h78);
		wcfg(LDCD_IDX_LDN, 8'h04);
		rcfg(LDCD_IDX_BASE_LO, 8'h00);
		wcfg(LDCD_IDX_LDN, 8'h03);
		wcfg(LDCD_IDX_ACT, 8'h01);
		chk(func_on, 12'h008);
		rcfg(LDCD_IDX_PWR, 8'h08);
		wcfg(LDCD_IDX_PWR, 8'h00);
		rcfg(LDCD_IDX_ACT, 8'h00);
		wcfg(LDCD_IDX_ACT, 8'h01);
		iord(16'h0378, 1, 3, 11'h000);
		iord(16'h0779, 1, 3, 11'h401);
		iord(16'h037b, 1, 3, 11'h003);
		wcfg(LDCD_IDX_BASE_LO, 8'h74);
		iord(16'h0376, 1, 3, 11'h002);
		iord(16'h0377, 0, 0, 0);
		wcfg(LDCD_IDX_BASE_LO, 8'h70);
		iord(16'h1373, 1, 3, 11'h003);
		wcfg(LDCD_IDX_OSC, 8'h40);
		iord(16'h1373, 0, 0, 0);
		wcfg(LDCD_IDX_LDN, 8'h07);
		wcfg(LDCD_IDX_ACT, 8'h01);
		iord(16'h0064, 1, 7, 11'h004);
		wcfg(LDCD_IDX_LDN, 8'h04);
		wcfg(LDCD_IDX_BASE_LO, 8'h80);
		wcfg(LDCD_IDX_ACT, 8'h01);
		iord(16'h0080, 0, 0, 0);
		wcfg(LDCD_IDX_BASE_HI, 8'h03);
		wcfg(LDCD_IDX_BASE_LO, 8'hf8);
		iord(16'h03ff, 1, 4, 11'h007);
		// line 2 first, then random selects
		for (i = 0; i < 4; i++) begin
			s = (i == 0) ? 4'h2 : 4'h1 + 4'({$random(seed)} % 15);
			wcfg(LDCD_IDX_IRQ, {4'h0, s});
			irq(12'h010, irq_of(s));
		end
		wcfg(LDCD_IDX_IRQ, 8'h00);
		// game port: one byte at any base in 100-FFF
		wcfg(LDCD_IDX_LDN, 8'h09);
		wcfg(LDCD_IDX_BASE_HI, 8'h02);
		wcfg(LDCD_IDX_BASE_LO, 8'h01);
		wcfg(LDCD_IDX_ACT, 8'h01);
		iord(16'h0201, 1, 9, 11'h000);
		iord(16'h0202, 0, 0, 0);
		wcfg(LDCD_IDX_LDN, 8'h03);
		wcfg(LDCD_IDX_IRQ, 8'h05);
		pp_ext_mode <= 1;
		irq(12'h008, 17'h00001);
		irq(12'h000, 17'h00041);
		// relocate the port, bit zero forced low, old port left unclaimed
		wcfg(LDCD_IDX_PORT_LO, 8'h4f);
		port = 16'h004e;
		rcfg(LDCD_IDX_PORT_LO, 8'h4e);
		i_host.cyc(0, 16'h002f, 8'h00, r);
		chk(r.claim, 1'b0);
		i_host.cyc(1, port, LDCD_KEY_EXIT, r);
		i_host.cyc(0, port + 16'h0001, 8'h00, r);
		chk(r.claim, 1'b0);
		stop_test();
	end
endmodule
